// File: hdl/dpw_pkg.sv
// Constants, register map and mode codes of the dual PWM / sigma-delta block.
// Assumes a 20 MHz system clock and a 32-bit classic Wishbone slave port.
package dpw_pkg;

    // ------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_A_LO = 8'h04;
    localparam logic [7:0] ADR_A_HI = 8'h08;
    localparam logic [7:0] ADR_B_LO = 8'h0c;
    localparam logic [7:0] ADR_B_HI = 8'h10;
    localparam logic [7:0] ADR_CNT = 8'h14;

    // ------------------------------------------------------------
    // Control field positions and reset value
    // ------------------------------------------------------------
    localparam int CTRL_MODE_LSB = 4;
    localparam int CTRL_PSC_LSB = 2;
    localparam int CTRL_CSEL_LSB = 0;
    localparam logic [7:0] CTRL_RST = 8'h00;

    // ------------------------------------------------------------
    // Clock source and prescaler codes
    // ------------------------------------------------------------
    localparam logic [1:0] CSEL_DIV15 = 2'h0;
    localparam logic [1:0] CSEL_SYS = 2'h1;
    localparam logic [1:0] CSEL_EXT = 2'h2;
    localparam logic [1:0] CSEL_FAST = 2'h3;
    localparam logic [3:0] SRC_DIV_TERM = 4'he;
    localparam logic [1:0] PSC_1 = 2'h0;
    localparam logic [1:0] PSC_4 = 2'h1;
    localparam logic [1:0] PSC_16 = 2'h2;
    localparam logic [5:0] PSC_TERM_1 = 6'h00;
    localparam logic [5:0] PSC_TERM_4 = 6'h03;
    localparam logic [5:0] PSC_TERM_16 = 6'h0f;
    localparam logic [5:0] PSC_TERM_64 = 6'h3f;

    // ------------------------------------------------------------
    // Operating modes
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_OFF = 3'h0,
        MODE_SINGLE = 3'h1,
        MODE_TWIN8 = 3'h2,
        MODE_TWIN16 = 3'h3,
        MODE_SD_NRZ = 3'h4,
        MODE_DUAL8 = 3'h5,
        MODE_SD_RZ = 3'h6,
        MODE_RSVD = 3'h7
    } dpw_mode_e;

endpackage

// File: hdl/dpw_sd_acc.sv
// First-order sigma-delta accumulator for one output channel.
// Assumes step and clr are one-cycle pulses on clk_sys.
`timescale 1ns/1ps
module dpw_sd_acc import dpw_pkg::*; (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Control
    input wire logic clr,
    input wire logic step,
    input wire logic [15:0] word,
    // Result
    output logic bit_out
);
    typedef struct packed {
        logic [15:0] acc;
        logic bit_v;
    } dpw_acc_s;

    dpw_acc_s q;
    dpw_acc_s d;
    logic [16:0] sum;

    always_comb begin
        d = q;
        sum = {1'b0, q.acc} + {1'b0, word};
        if (clr) begin
            d = '0;
        end else if (step) begin
            // Carry out is the output bit
            d.acc = sum[15:0];
            d.bit_v = sum[16];
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign bit_out = q.bit_v;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);

    sd_zero_word_a: assert property ((step && !clr && word == 16'h0000)
        |=> !bit_out) else $error("zero word produced a carry");
    sd_full_word_a: assert property ((step && !clr && word == 16'hffff
        && q.acc != 16'h0000) |=> bit_out)
        else $error("full word failed to carry");
endmodule

// File: hdl/dpw_core.sv
// Dual PWM and sigma-delta DAC with a Wishbone register port.
// Assumes a 20 MHz clk_sys and an external clock pin from another domain.
//
// How it works
// - Single mode: compare_b_word sets the period
// - Single mode: compare_a_word sets duty cycle
// - Twin 8-bit: compare_b_low is common period
// - Twin 8-bit: output_a low from compare_a_low
// - Twin 8-bit: output_b high at b_high, low a_high
// - Twin 8-bit: b_high zero starts both together
// - Twin 16-bit: counter wraps over full range
// - Twin 16-bit: high below own compare word
// - Twin 16-bit: both outputs rise at wrap
// - Sigma-delta updates outputs every PWM clock
// - Sigma-delta high count equals compare word
// - Dual 8-bit: separate periods and duty bytes
// - Dual 8-bit: one clock source and prescaler
// - Return-to-zero: high bits last half clock at /4 and /16, whole clock at divide-by-one; /64 keeps outputs low
// - Three-bit mode field, zero off, seven reserved
// - 16-bit modes: low byte held, high write loads both
// - Control write clears the counter
// - Prescaler divides by 1, 4, 16, 64
//
// The register addresses and the Wishbone register port were decided locally.
`timescale 1ns/1ps
module dpw_core import dpw_pkg::*; (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // External PWM clock pin
    input wire logic pin_clk_in,
    // Output pins
    output logic pin_out_a,
    output logic pin_oe_a,
    output logic pin_out_b,
    output logic pin_oe_b
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic ack;
        logic [31:0] rdat;
        logic [7:0] ctrl;
        logic [7:0] hold_a;
        logic [7:0] hold_b;
        logic [15:0] pend_a;
        logic [15:0] pend_b;
        logic [15:0] act_a;
        logic [15:0] act_b;
        logic [2:0] ext_sync;
        logic ext_lvl;
        logic [3:0] src_cnt;
        logic [5:0] psc_cnt;
        logic [15:0] cnt;
        logic [7:0] cnt_b;
        logic out_a;
        logic out_b;
        logic oe_a;
        logic oe_b;
    } dpw_state_s;

    dpw_state_s q;
    dpw_state_s d;

    dpw_mode_e mode;
    dpw_mode_e new_mode;
    logic active;
    logic ext_rise;
    logic src_tick;
    logic tick;
    logic [5:0] psc_term;
    logic [5:0] half;
    logic rz_high;
    logic sd_mode;
    logic sd_step;
    logic sd_bit_a;
    logic sd_bit_b;
    logic la;
    logic lb;
    logic [15:0] na;
    logic [7:0] n8;
    logic [7:0] nb8;
    logic req;
    logic wr;
    logic ctrl_wr;
    logic is16;
    logic [31:0] rd;

    // ------------------------------------------------------------
    // Sigma-delta channels
    // ------------------------------------------------------------
    dpw_sd_acc u_sd_a (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .clr(ctrl_wr),
        .step(sd_step),
        .word(q.pend_a),
        .bit_out(sd_bit_a)
    );

    dpw_sd_acc u_sd_b (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .clr(ctrl_wr),
        .step(sd_step),
        .word(q.pend_b),
        .bit_out(sd_bit_b)
    );

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        d.ack = 1'b0;
        la = 1'b0;
        lb = 1'b0;
        na = 16'h0000;
        n8 = 8'h00;
        nb8 = 8'h00;
        ext_rise = 1'b0;
        src_tick = 1'b0;
        tick = 1'b0;
        rd = 32'h0000_0000;
        mode = dpw_mode_e'(q.ctrl[CTRL_MODE_LSB +: 3]);
        // Reserved code behaves as disabled
        active = mode != MODE_OFF && mode != MODE_RSVD;
        sd_mode = mode == MODE_SD_NRZ || mode == MODE_SD_RZ;
        is16 = mode == MODE_SINGLE || mode == MODE_TWIN16 || sd_mode;
        // External clock: accepted once stages two and three agree
        d.ext_sync = {q.ext_sync[1:0], pin_clk_in};
        if (q.ext_sync[2] == q.ext_sync[1] && q.ext_sync[2] != q.ext_lvl) begin
            d.ext_lvl = q.ext_sync[2];
            ext_rise = q.ext_sync[2];
        end
        // Source selection, shared by both channels
        case (q.ctrl[CTRL_CSEL_LSB +: 2])
            CSEL_DIV15: begin
                if (q.src_cnt == SRC_DIV_TERM) begin
                    d.src_cnt = 4'h0;
                    src_tick = 1'b1;
                end else begin
                    d.src_cnt = q.src_cnt + 4'h1;
                end
            end
            CSEL_EXT: src_tick = ext_rise;
            default: src_tick = 1'b1;
        endcase
        unique case (q.ctrl[CTRL_PSC_LSB +: 2])
            PSC_1: psc_term = PSC_TERM_1;
            PSC_4: psc_term = PSC_TERM_4;
            PSC_16: psc_term = PSC_TERM_16;
            default: psc_term = PSC_TERM_64;
        endcase
        half = 6'((psc_term + 6'h01) >> 1);
        // Counter holds while disabled
        if (src_tick && active) begin
            if (q.psc_cnt >= psc_term) begin
                d.psc_cnt = 6'h00;
                tick = 1'b1;
            end else begin
                d.psc_cnt = q.psc_cnt + 6'h01;
            end
        end
        sd_step = tick && sd_mode;
        // With divide-by-one no half clock exists, so RZ degrades to NRZ
        rz_high = psc_term == PSC_TERM_1 || q.psc_cnt < half;
        if (!active) begin
            d.act_a = q.pend_a;
            d.act_b = q.pend_b;
            d.out_a = 1'b0;
            d.out_b = 1'b0;
        end else if (sd_mode) begin
            d.act_a = q.pend_a;
            d.act_b = q.pend_b;
            // Refreshed every clk_sys cycle, gated for return-to-zero
            d.out_a = sd_bit_a && (mode == MODE_SD_NRZ || rz_high);
            d.out_b = sd_bit_b && (mode == MODE_SD_NRZ || rz_high);
        end else if (tick) begin
            unique case (mode)
                MODE_SINGLE: begin
                    la = q.cnt >= q.act_b;
                    na = la ? 16'h0000 : q.cnt + 16'h0001;
                    if (la) begin
                        d.act_a = q.pend_a;
                        d.act_b = q.pend_b;
                    end
                    d.cnt = na;
                    d.out_a = na < d.act_a;
                end
                MODE_TWIN8: begin
                    la = q.cnt[7:0] >= q.act_b[7:0];
                    n8 = la ? 8'h00 : q.cnt[7:0] + 8'h01;
                    if (la) begin
                        d.act_a = q.pend_a;
                        d.act_b = q.pend_b;
                    end
                    d.cnt = {8'h00, n8};
                    d.out_a = n8 < d.act_a[7:0];
                    if (n8 == d.act_b[15:8]) begin
                        d.out_b = 1'b1;
                    end else if (n8 == d.act_a[15:8]) begin
                        d.out_b = 1'b0;
                    end
                end
                MODE_TWIN16: begin
                    la = q.cnt == 16'hffff;
                    na = q.cnt + 16'h0001;
                    if (la) begin
                        d.act_a = q.pend_a;
                        d.act_b = q.pend_b;
                    end
                    d.cnt = na;
                    d.out_a = na < d.act_a;
                    d.out_b = na < d.act_b;
                end
                default: begin
                    la = q.cnt[7:0] >= q.act_b[7:0];
                    n8 = la ? 8'h00 : q.cnt[7:0] + 8'h01;
                    lb = q.cnt_b >= q.act_b[15:8];
                    nb8 = lb ? 8'h00 : q.cnt_b + 8'h01;
                    if (la) begin
                        d.act_a[7:0] = q.pend_a[7:0];
                        d.act_b[7:0] = q.pend_b[7:0];
                    end
                    if (lb) begin
                        d.act_a[15:8] = q.pend_a[15:8];
                        d.act_b[15:8] = q.pend_b[15:8];
                    end
                    d.cnt = {8'h00, n8};
                    d.cnt_b = nb8;
                    d.out_a = n8 < d.act_a[7:0];
                    d.out_b = nb8 < d.act_a[15:8];
                end
            endcase
        end

        // Bus slave: one wait state, unmapped reads return zero
        req = wb_cyc_i && wb_stb_i && !q.ack;
        wr = req && wb_we_i && wb_sel_i[0];
        ctrl_wr = wr && wb_adr_i == ADR_CTRL;
        case (wb_adr_i)
            ADR_CTRL: rd = {24'h000000, q.ctrl};
            ADR_A_LO: rd = {24'h000000, q.pend_a[7:0]};
            ADR_A_HI: rd = {24'h000000, q.pend_a[15:8]};
            ADR_B_LO: rd = {24'h000000, q.pend_b[7:0]};
            ADR_B_HI: rd = {24'h000000, q.pend_b[15:8]};
            ADR_CNT: rd = {8'h00, q.cnt_b, q.cnt};
            default: rd = 32'h0000_0000;
        endcase
        if (req) begin
            d.ack = 1'b1;
            d.rdat = wb_we_i ? 32'h0000_0000 : rd;
        end
        if (wr) begin
            case (wb_adr_i)
                ADR_CTRL: begin
                    d.ctrl = {1'b0, wb_dat_i[6:0]};
                    d.cnt = 16'h0000;
                    d.cnt_b = 8'h00;
                    d.psc_cnt = 6'h00;
                    d.src_cnt = 4'h0;
                end
                ADR_A_LO: begin
                    d.hold_a = wb_dat_i[7:0];
                    if (!is16) begin
                        d.pend_a[7:0] = wb_dat_i[7:0];
                    end
                end
                ADR_A_HI: begin
                    if (is16) begin
                        d.pend_a = {wb_dat_i[7:0], q.hold_a};
                    end else begin
                        d.pend_a[15:8] = wb_dat_i[7:0];
                    end
                end
                ADR_B_LO: begin
                    d.hold_b = wb_dat_i[7:0];
                    if (!is16) begin
                        d.pend_b[7:0] = wb_dat_i[7:0];
                    end
                end
                ADR_B_HI: begin
                    if (is16) begin
                        d.pend_b = {wb_dat_i[7:0], q.hold_b};
                    end else begin
                        d.pend_b[15:8] = wb_dat_i[7:0];
                    end
                end
                default: begin
                end
            endcase
        end

        // Pins released to port use when disabled
        new_mode = dpw_mode_e'(d.ctrl[CTRL_MODE_LSB +: 3]);
        d.oe_a = new_mode != MODE_OFF && new_mode != MODE_RSVD;
        d.oe_b = d.oe_a && new_mode != MODE_SINGLE;
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            q <= '0;
            q.ctrl <= CTRL_RST;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign wb_ack_o = q.ack;
    assign wb_dat_o = q.rdat;
    assign pin_out_a = q.out_a;
    assign pin_out_b = q.out_b;
    assign pin_oe_a = q.oe_a;
    assign pin_oe_b = q.oe_b;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);

    ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    ctrl_clear_a: assert property (ctrl_wr |=> q.cnt == 16'h0000
        && q.cnt_b == 8'h00) else $error("control write kept count");
    off_release_a: assert property ((!active && !$past(ctrl_wr))
        |-> !pin_oe_a && !pin_oe_b && !pin_out_a)
        else $error("pins driven while disabled");
    off_hold_a: assert property ((!active && !ctrl_wr) |=> $stable(q.cnt))
        else $error("counter moved while disabled");
    wrap16_a: assert property ((mode == MODE_TWIN16 && tick
        && q.cnt == 16'hffff && !ctrl_wr) |=> q.cnt == 16'h0000
        && pin_out_a == ($past(q.pend_a) != 16'h0000)
        && pin_out_b == ($past(q.pend_b) != 16'h0000))
        else $error("twin 16-bit wrap wrong");
    single_wrap_a: assert property ((mode == MODE_SINGLE && tick
        && q.cnt >= q.act_b && !ctrl_wr) |=> q.cnt == 16'h0000)
        else $error("single mode missed period end");
    psc_four_a: assert property (disable iff (sys_rst || ctrl_wr)
        (tick && q.ctrl[1:0] == CSEL_SYS && q.ctrl[3:2] == PSC_4)
        |=> !tick [*3] ##1 tick) else $error("prescale four wrong");
    twin8_low_a: assert property ((mode == MODE_TWIN8 && $past(tick)
        && !$past(ctrl_wr) && q.cnt[7:0] >= q.act_a[7:0]) |-> !pin_out_a)
        else $error("twin 8-bit output_a late low");
    sd_idle_a: assert property ((mode == MODE_SD_NRZ && tick
        && q.pend_a == 16'h0000 && !wr) |=> ##1 !pin_out_a)
        else $error("zero word drove sigma-delta high");
    single_cov: cover property (mode == MODE_SINGLE && tick && la);
    twin8_cov: cover property (mode == MODE_TWIN8 && $rose(pin_out_b));
    dual8_cov: cover property (mode == MODE_DUAL8 && tick && lb);
    rz_cov: cover property (mode == MODE_SD_RZ && $fell(pin_out_a));
endmodule

// File: verif/dpw_load.sv
// Load model on the two PWM pins: counts clock cycles driven high.
// Assumes pins are registered on clk_sys; a pin whose enable is low is
// treated as floating and never counts as high.
`timescale 1ns/1ps
module dpw_load (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Pins
    input wire logic pin_out_a,
    input wire logic pin_oe_a,
    input wire logic pin_out_b,
    input wire logic pin_oe_b,
    // Running high counts
    output int cnt_a,
    output int cnt_b
);
    // Free-running totals; the bench takes differences over windows
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_a <= 0;
            cnt_b <= 0;
        end else begin
            if ((pin_oe_a & pin_out_a) === 1'b1) begin
                cnt_a <= cnt_a + 1;
            end
            if ((pin_oe_b & pin_out_b) === 1'b1) begin
                cnt_b <= cnt_b + 1;
            end
        end
    end
endmodule

// File: verif/dpw_core_tb.sv
// Self-checking bench for the dual PWM / sigma-delta block.
// Assumes the register map of dpw_pkg and one-wait-state Wishbone acks.
`timescale 1ns/1ps
module dpw_core_tb;
    import dpw_pkg::*;
    logic clk_sys = 0;
    logic sys_rst = 1;
    logic cyc = 0, stb = 0, we = 0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 32'h0;
    logic [31:0] rdat, r;
    logic ack, out_a, oe_a, out_b, oe_b;
    int cnt_a, cnt_b, err_total = 0, n_tests = 0;
    int seed = 32'hfc05;
    int p, d, h, q, e, wa, wb, dv;
    logic ext_clk = 0;
    int ext_n = 0;
    always #25 clk_sys = ~clk_sys;
    // External clock pin: one rising edge every 6 cycles, slow enough to sync
    always @(posedge clk_sys) begin
        ext_n <= (ext_n == 2) ? 0 : ext_n + 1;
        if (ext_n == 2) begin
            ext_clk <= ~ext_clk;
        end
    end
    dpw_core u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .pin_clk_in(ext_clk),
        .pin_out_a(out_a), .pin_oe_a(oe_a), .pin_out_b(out_b),
        .pin_oe_b(oe_b));
    dpw_load u_load (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .pin_out_a(out_a), .pin_oe_a(oe_a), .pin_out_b(out_b),
        .pin_oe_b(oe_b), .cnt_a(cnt_a), .cnt_b(cnt_b));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Classic cycle: hold everything until ack is sampled high
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [7:0] v);
        int n;
        @(posedge clk_sys);
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= a;
        sel <= 4'h1;
        dat <= {24'h0, v};
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (ack !== 1'b1 && n < 20);
        r = rdat;
        cyc <= 0;
        stb <= 0;
        we <= 0;
        if (n >= 20) begin
            err_total++;
            $display("unexpected at %0t got %h exp %h", $time, n, 1);
            stop_test();
        end
    endtask
    function automatic logic [7:0] cw(int m, int ps, int cs);
        return {1'b0, m[2:0], ps[1:0], cs[1:0]};
    endfunction
    function automatic int div_of(int ps);
        return 1 << (2 * ps);
    endfunction
    // Byte writes in mode 0 land in the active compare values at once
    task automatic setup(input logic [7:0] c, al, ah, bl, bh);
        bus(1, ADR_CTRL, 8'h00);
        bus(1, ADR_A_LO, al);
        bus(1, ADR_A_HI, ah);
        bus(1, ADR_B_LO, bl);
        bus(1, ADR_B_HI, bh);
        bus(1, ADR_CTRL, c);
    endtask
    task automatic run(input int settle, win, ea, eb, input string nm);
        int a0, b0;
        repeat (settle) @(posedge clk_sys);
        a0 = cnt_a;
        b0 = cnt_b;
        repeat (win) @(posedge clk_sys);
        chk(cnt_a - a0, ea);
        chk(cnt_b - b0, eb);
        $display("test %s done", nm);
    endtask
    initial begin
        #(100000 * 50);
        err_total++;
        stop_test();
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (5) @(posedge clk_sys);
        sys_rst <= 0;
        bus(0, ADR_CTRL, 8'h00);
        chk(r, {24'h0, CTRL_RST});
        bus(0, 8'h1c, 8'h00);
        chk(r, 32'h0);
        run(2, 50, 0, 0, "off");
        // Twin 8-bit over every prescale, then the /15 and external sources
        for (int i = 0; i < 6; i++) begin
            p = 3 + ($unsigned($random(seed)) % 13);
            d = $unsigned($random(seed)) % (p + 1);
            h = 1 + ($unsigned($random(seed)) % p);
            dv = (i < 4) ? div_of(i) : (i == 4) ? 15 : 24;
            setup(cw(2, i % 4, (i < 4) ? 1 : 2 * (i - 4)), d, h, p, 0);
            e = (p + 1) * dv;
            run(e + 20, 2 * e, 2 * d * dv, 2 * h * dv, "twin8");
        end
        p = 2 + ($unsigned($random(seed)) % 8);
        q = 2 + ($unsigned($random(seed)) % 8);
        d = $unsigned($random(seed)) % (p + 1);
        h = $unsigned($random(seed)) % (q + 1);
        setup(cw(5, 1, 1), d, h, p, q);
        e = (p + 1) * (q + 1) * 4;
        run(e, e, d * (q + 1) * 4, h * (p + 1) * 4, "dual8");
        wb = 32 + ($unsigned($random(seed)) % 32);
        wa = $unsigned($random(seed)) % (wb + 1);
        setup(cw(1, 0, 1), wa, 0, wb, 0);
        run(wb + 20, 2 * (wb + 1), 2 * wa, 0, "single");
        // Corner words: zero never carries, full scale carries every step after the first
        setup(cw(4, 0, 3), 0, 0, 8'hff, 8'hff);
        run(8, 256, 0, 256, "sd_edge");
        // Zeroed low bytes make the pattern repeat every 256 ticks
        wa = $unsigned($random(seed)) % 256;
        wb = 8'h40;
        setup(cw(4, 0, 3), 0, wa, 0, wb);
        run(8, 256, wa, wb, "sd_nrz");
        setup(cw(6, 1, 1), 0, wa, 0, wb);
        run(16, 1024, 2 * wa, 2 * wb, "sd_rz");
        wa = $unsigned($random(seed)) % 65536;
        wb = 16'hffff;
        setup(cw(3, 0, 1), wa[7:0], wa[15:8], wb[7:0], wb[15:8]);
        run(8, 65536, wa, wb, "twin16");
        bus(0, ADR_CNT, 8'h00);
        bus(1, ADR_CTRL, cw(3, 0, 1));
        bus(0, ADR_CNT, 8'h00);
        chk(r[15:0] < 16, 1);
        chk(r[31:16], 32'h0);
        bus(1, ADR_A_LO, 8'h5a);
        bus(0, ADR_A_LO, 8'h00);
        chk(r, {24'h0, wa[7:0]});
        bus(1, ADR_A_HI, 8'h01);
        bus(0, ADR_A_LO, 8'h00);
        chk(r, 32'h5a);
        bus(1, ADR_CTRL, cw(7, 0, 1));
        run(4, 100, 0, 0, "reserved");
        stop_test();
    end
endmodule
